// File: hdl/biquinary_code_translate_check.sv
/*
 * bi-quinary to storage code translator, storage to bi-quinary translator,
 * storage read latches and three capacitor storage validity checkers.
 * assumes program control gives gates aligned to clk, b_time/a_time pulses
 * mark the middle and end of each digit time.
 */
`include "biquinary_map.svh"
`timescale 1ns/100ps
`default_nettype none
module biquinary_code_translate_check (
   input wire logic clk, // 250 MHz clock
   input wire logic rst_n, // synchronous reset
   input wire logic [`BQ_WIDTH-1:0] dist_digit, // distributor 2-of-7 digit
   input wire logic [`BQ_WIDTH-1:0] read_buf_digit, // read buffer 2-of-7 digit
   input wire logic store_transfer_gate, // store operation gate
   input wire logic buffer_to_main_transfer_gate, // read operation gate
   input wire logic [`SC_WIDTH-1:0] storage_sense, // sampled recorded bits
   input wire logic b_time, // read sample pulse
   input wire logic a_time, // latch-reset pulse
   input wire logic manual_read_in, // manual read-in to storage
   input wire logic punch_buffer_gate, // punch buffer read-in gate
   input wire logic [`BQ_WIDTH-1:0] acc_digit, // accumulator digit
   input wire logic [`BQ_WIDTH-1:0] pgm_digit, // program register digit
   input wire logic [`BQ_WIDTH-1:0] chk_dist_digit, // distributor checked digit
   input wire logic digit_strobe, // digit time of the units
   input wire logic error_reset, // explicit error reset
   output logic [`SC_WIDTH-1:0] storage_write, // 2-of-5 to write circuits
   output logic [`SC_WIDTH-1:0] read_latch, // storage read latches
   output logic [`BQ_WIDTH-1:0] selected_line, // 2-of-7 to selected line
   output logic [`BQ_WIDTH-1:0] punch_buffer_out, // 2-of-7 to punch buffer
   output logic [`CHK_UNITS-1:0] error_light, // per-unit error indicator
   output logic machine_stop // stop request
);
   typedef struct packed {
      logic [`SC_WIDTH-1:0] wr;
      logic [`SC_WIDTH-1:0] latch;
      logic [`BQ_WIDTH-1:0] sel;
      logic [`BQ_WIDTH-1:0] pun;
      logic [`CHK_UNITS-1:0] light;
      logic stop;
      biquinary_pkg::latch_phase_t ph;
   } top_state_t;
   top_state_t s_q;
   top_state_t s_d;
   biquinary_pkg::bq_digit_t in_digit;
   biquinary_pkg::sc_digit_t enc;
   biquinary_pkg::bq_digit_t dec;
   biquinary_pkg::unit_vec_t unit_err;
   logic [`BQ_WIDTH-1:0] unit_digit [`CHK_UNITS];

   ////////////////////////////////////////////////////////////////////////
   // 7-to-5 matrix
   function automatic biquinary_pkg::sc_digit_t to_storage(input biquinary_pkg::bq_digit_t d);
      logic b0;
      logic b5;
      logic [4:0] q;
      b0 = d[`BQ_B0];
      b5 = d[`BQ_B5];
      q = d[`BQ_Q4:`BQ_Q0];
      to_storage = `SC_ZERO;
      to_storage[`SC_W0] = q[1] | (b0 & (q[2] | q[3]));
      to_storage[`SC_W1] = (b0 & (q[0] | q[1] | q[4])) | (b5 & q[2]);
      to_storage[`SC_W2] = q[0] | (b0 & q[2]) | (b5 & q[3]);
      to_storage[`SC_W3] = q[4] | (b0 & q[3]) | (b5 & q[0]);
      to_storage[`SC_W6] = b5 & (q[1] | q[2] | q[3] | q[4]);
   endfunction : to_storage

   // 5-to-7 matrix
   function automatic biquinary_pkg::bq_digit_t to_biquinary(input biquinary_pkg::sc_digit_t s);
      logic w0;
      logic w1;
      logic w2;
      logic w3;
      logic w6;
      w0 = s[`SC_W0];
      w1 = s[`SC_W1];
      w2 = s[`SC_W2];
      w3 = s[`SC_W3];
      w6 = s[`SC_W6];
      to_biquinary = `BQ_ZERO;
      to_biquinary[`BQ_Q0] = w2 & (w1 | w3);
      to_biquinary[`BQ_Q1] = w0 & (w1 | w6);
      to_biquinary[`BQ_Q2] = (w2 & w0) | (w6 & w1);
      to_biquinary[`BQ_Q3] = (w3 & w0) | (w6 & w2);
      to_biquinary[`BQ_Q4] = w3 & (w1 | w6);
      to_biquinary[`BQ_B0] = (w1 & w2) | (w1 & w0) | (w2 & w0) | (w3 & w0) | (w3 & w1);
      to_biquinary[`BQ_B5] = w6 | (w3 & w2);
   endfunction : to_biquinary

   ////////////////////////////////////////////////////////////////////////
   // input selection: store takes the distributor, read takes the buffer
   always_comb begin
      in_digit = `BQ_ZERO;
      if (store_transfer_gate) begin
         in_digit = dist_digit;
      end else if (buffer_to_main_transfer_gate) begin
         in_digit = read_buf_digit;
      end
      enc = to_storage(in_digit);
      dec = to_biquinary(s_q.latch);
   end

   ////////////////////////////////////////////////////////////////////////
   // three independent checkers, one per capacitor storage unit
   assign unit_digit[`CHK_ACC] = acc_digit;
   assign unit_digit[`CHK_PGM] = pgm_digit;
   assign unit_digit[`CHK_DIST] = chk_dist_digit;

   for (genvar u = 0; u < `CHK_UNITS; u++) begin : g_chk
      validity_checker u_chk (
         .clk(clk),
         .rst_n(rst_n),
         .digit(unit_digit[u]),
         .digit_strobe(digit_strobe),
         .error_reset(error_reset),
         .error_latch(unit_err[u])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: write lines, read latches, converted outputs, indicators
   always_comb begin
      s_d = s_q;
      s_d.wr = enc;
      // reset at A time wins so the gate ends sharply; set follows at B
      if (a_time) begin
         s_d.latch = `SC_ZERO;
         s_d.ph = biquinary_pkg::PH_IDLE;
      end else if (b_time) begin
         s_d.latch = storage_sense;
         s_d.ph = biquinary_pkg::PH_HELD;
      end
      // converted gates dropped at A time; selected line blocked on manual read-in, punch line needs punch_buffer_gate
      if (a_time || s_q.ph == biquinary_pkg::PH_IDLE) begin
         s_d.sel = `BQ_ZERO;
         s_d.pun = `BQ_ZERO;
      end else begin
         s_d.sel = manual_read_in ? `BQ_ZERO : dec;
         s_d.pun = punch_buffer_gate ? dec : `BQ_ZERO;
      end
      s_d.light = unit_err;
      s_d.stop = |unit_err;
   end

   // one register for the whole state keeps every output registered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign storage_write = s_q.wr;
   assign read_latch = s_q.latch;
   assign selected_line = s_q.sel;
   assign punch_buffer_out = s_q.pun;
   assign error_light = s_q.light;
   assign machine_stop = s_q.stop;

   ////////////////////////////////////////////////////////////////////////
   property p_no_gate_no_write;
      @(posedge clk) disable iff (!rst_n) !store_transfer_gate && !buffer_to_main_transfer_gate
         |=> storage_write == `SC_ZERO;
   endproperty
   a_no_gate_no_write: assert property (p_no_gate_no_write) else $error("write without gate");

   property p_w6;
      @(posedge clk) disable iff (!rst_n) store_transfer_gate && dist_digit == 7'h0a |=> storage_write == 5'h11;
   endproperty
   a_w6: assert property (p_w6) else $error("digit 6 not encoded as 0-6");

   property p_w0;
      @(posedge clk) disable iff (!rst_n) store_transfer_gate && dist_digit == 7'h0005 |=> storage_write == 5'h0006;
   endproperty
   a_w0: assert property (p_w0) else $error("digit 0 not encoded as 1-2");

   property p_latch_clear;
      @(posedge clk) disable iff (!rst_n) a_time |=> read_latch == `SC_ZERO ##1 (selected_line == `BQ_ZERO);
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared at A time");

   property p_latch_set;
      @(posedge clk) disable iff (!rst_n) b_time && !a_time |=> read_latch == $past(storage_sense);
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set at B time");

   property p_manual_block;
      @(posedge clk) disable iff (!rst_n) manual_read_in |=> selected_line == `BQ_ZERO;
   endproperty
   a_manual_block: assert property (p_manual_block) else $error("latch output on manual read-in");

   property p_decode;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h11 && !a_time && !manual_read_in
         |=> selected_line == 7'h0a;
   endproperty
   a_decode: assert property (p_decode) else $error("0-6 not decoded as 6");

   property p_stop;
      @(posedge clk) disable iff (!rst_n) |unit_err |=> machine_stop && error_light == $past(unit_err);
   endproperty
   a_stop: assert property (p_stop) else $error("error did not stop machine");

   ////////////////////////////////////////////////////////////////////////
   // digit table through the 7-to-5 matrix; a wrong product term can still
   // leave two bits up, so each digit is pinned to its own storage code
   property p_enc_1;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h09 |=> storage_write == 5'h03;
   endproperty
   a_enc_1: assert property (p_enc_1) else $error("digit 1 not encoded as 0-1");

   property p_enc_2;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h11 |=> storage_write == 5'h05;
   endproperty
   a_enc_2: assert property (p_enc_2) else $error("digit 2 not encoded as 0-2");

   property p_enc_3;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h21 |=> storage_write == 5'h09;
   endproperty
   a_enc_3: assert property (p_enc_3) else $error("digit 3 not encoded as 0-3");

   property p_enc_4;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h41 |=> storage_write == 5'h0a;
   endproperty
   a_enc_4: assert property (p_enc_4) else $error("digit 4 not encoded as 1-3");

   property p_enc_5;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h06 |=> storage_write == 5'h0c;
   endproperty
   a_enc_5: assert property (p_enc_5) else $error("digit 5 not encoded as 2-3");

   property p_enc_7;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h12 |=> storage_write == 5'h12;
   endproperty
   a_enc_7: assert property (p_enc_7) else $error("digit 7 not encoded as 1-6");

   property p_enc_8;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h22 |=> storage_write == 5'h14;
   endproperty
   a_enc_8: assert property (p_enc_8) else $error("digit 8 not encoded as 2-6");

   property p_enc_9;
      @(posedge clk) disable iff (!rst_n) in_digit == 7'h42 |=> storage_write == 5'h18;
   endproperty
   a_enc_9: assert property (p_enc_9) else $error("digit 9 not encoded as 3-6");

   // digit table back through the 5-to-7 matrix; manual read-in and the
   // A-time cut are left out because both force the line to zero
   property p_dec_0;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h06 && !a_time && !manual_read_in
         |=> selected_line == 7'h05;
   endproperty
   a_dec_0: assert property (p_dec_0) else $error("1-2 not decoded as 0");

   property p_dec_1;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h03 && !a_time && !manual_read_in
         |=> selected_line == 7'h09;
   endproperty
   a_dec_1: assert property (p_dec_1) else $error("0-1 not decoded as 1");

   property p_dec_2;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h05 && !a_time && !manual_read_in
         |=> selected_line == 7'h11;
   endproperty
   a_dec_2: assert property (p_dec_2) else $error("0-2 not decoded as 2");

   property p_dec_3;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h09 && !a_time && !manual_read_in
         |=> selected_line == 7'h21;
   endproperty
   a_dec_3: assert property (p_dec_3) else $error("0-3 not decoded as 3");

   property p_dec_4;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h0a && !a_time && !manual_read_in
         |=> selected_line == 7'h41;
   endproperty
   a_dec_4: assert property (p_dec_4) else $error("1-3 not decoded as 4");

   property p_dec_5;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h0c && !a_time && !manual_read_in
         |=> selected_line == 7'h06;
   endproperty
   a_dec_5: assert property (p_dec_5) else $error("2-3 not decoded as 5");

   property p_dec_7;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h12 && !a_time && !manual_read_in
         |=> selected_line == 7'h12;
   endproperty
   a_dec_7: assert property (p_dec_7) else $error("1-6 not decoded as 7");

   property p_dec_8;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h14 && !a_time && !manual_read_in
         |=> selected_line == 7'h22;
   endproperty
   a_dec_8: assert property (p_dec_8) else $error("2-6 not decoded as 8");

   property p_dec_9;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h18 && !a_time && !manual_read_in
         |=> selected_line == 7'h42;
   endproperty
   a_dec_9: assert property (p_dec_9) else $error("3-6 not decoded as 9");

   // punch path gating, gate priority and the held stop request
   property p_pun_block;
      @(posedge clk) disable iff (!rst_n) !punch_buffer_gate |=> punch_buffer_out == `BQ_ZERO;
   endproperty
   a_pun_block: assert property (p_pun_block) else $error("punch buffer fed without gate");

   property p_pun_pass;
      @(posedge clk) disable iff (!rst_n) read_latch == 5'h06 && !a_time && punch_buffer_gate
         |=> punch_buffer_out == 7'h05;
   endproperty
   a_pun_pass: assert property (p_pun_pass) else $error("punch buffer missed converted digit");

   property p_priority;
      @(posedge clk) disable iff (!rst_n) store_transfer_gate && buffer_to_main_transfer_gate && dist_digit == 7'h42
         |=> storage_write == 5'h18;
   endproperty
   a_priority: assert property (p_priority) else $error("store gate did not take priority");

   property p_stop_hold;
      @(posedge clk) disable iff (!rst_n) machine_stop && !error_reset && !$past(error_reset)
         |=> machine_stop;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop dropped without reset");

   property p_quiet;
      @(posedge clk) disable iff (!rst_n) unit_err == `CHK_ZERO |=> !machine_stop && error_light == `CHK_ZERO;
   endproperty
   a_quiet: assert property (p_quiet) else $error("stop or light without error");
endmodule : biquinary_code_translate_check
`default_nettype wire

// File: hdl/validity_checker.sv
/*
 * one 2-of-7 validity checker with its sticky error latch.
 * assumes digit_strobe marks each digit time of the monitored unit.
 */
`include "biquinary_map.svh"
`timescale 1ns/100ps
`default_nettype none
module validity_checker (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronous reset
   input wire logic [`BQ_WIDTH-1:0] digit, // monitored 2-of-7 bus
   input wire logic digit_strobe, // digit time present
   input wire logic error_reset, // explicit error reset
   output logic error_latch // sticky error latch
);
   typedef struct packed {
      logic err;
   } chk_state_t;
   chk_state_t s_q;
   chk_state_t s_d;
   logic bad;

   // true when a group does not hold exactly one bit
   function automatic logic not_one_hot(input logic [4:0] v, input logic [2:0] n);
      logic [2:0] cnt;
      cnt = 3'h0;
      for (int i = 0; i < 5; i++) begin
         if (i < n) begin
            cnt = cnt + {2'b00, v[i]};
         end
      end
      not_one_hot = (cnt != 3'h1);
   endfunction : not_one_hot

   ////////////////////////////////////////////////////////////////////////
   // extra or missing binary or quinary bit
   always_comb begin
      bad = not_one_hot({3'b000, digit[`BQ_B5], digit[`BQ_B0]}, 3'h2)
         | not_one_hot(digit[`BQ_Q4:`BQ_Q0], 3'h5);
      s_d = s_q;
      if (digit_strobe && bad) begin
         s_d.err = 1'b1; // set wins over reset
      end else if (error_reset) begin
         s_d.err = 1'b0;
      end
   end

   // new good digits never clear the latch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign error_latch = s_q.err;

   property p_sticky;
      @(posedge clk) disable iff (!rst_n) error_latch && !error_reset |=> error_latch;
   endproperty
   a_sticky: assert property (p_sticky) else $error("error latch dropped without reset");

   property p_set;
      @(posedge clk) disable iff (!rst_n) digit_strobe && (digit[`BQ_B0] == digit[`BQ_B5]) |=> error_latch;
   endproperty
   a_set: assert property (p_set) else $error("bad binary pair not latched");
endmodule : validity_checker
`default_nettype wire

// File: include/biquinary_map.svh
/*
 * bit positions and zero constants for the bi-quinary (2-of-7) and storage (2-of-5) digit codes.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef BIQUINARY_MAP_SVH
`define BIQUINARY_MAP_SVH
// 2-of-7 bus bit positions: binary weights then quinary weights
`define BQ_B0 0
`define BQ_B5 1
`define BQ_Q0 2
`define BQ_Q1 3
`define BQ_Q2 4
`define BQ_Q3 5
`define BQ_Q4 6
`define BQ_WIDTH 7
// 2-of-5 storage line bit positions, weights 0,1,2,3,6
`define SC_W0 0
`define SC_W1 1
`define SC_W2 2
`define SC_W3 3
`define SC_W6 4
`define SC_WIDTH 5
// number of capacitor storage units watched
`define CHK_UNITS 3
`define CHK_ACC 0
`define CHK_PGM 1
`define CHK_DIST 2
`define BQ_ZERO 7'h00
`define SC_ZERO 5'h00
`define CHK_ZERO 3'h0
`endif

// File: include/biquinary_pkg.sv
/*
 * types used by the digit translator; its validity checker uses none of them.
 * assumes biquinary_map.svh is on the include path.
 */
`include "biquinary_map.svh"
package biquinary_pkg;
   typedef logic [`BQ_WIDTH-1:0] bq_digit_t;
   typedef logic [`SC_WIDTH-1:0] sc_digit_t;
   typedef logic [`CHK_UNITS-1:0] unit_vec_t;
   // phase of the storage read latch within one digit time
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_HELD = 2'b01
   } latch_phase_t;
endpackage : biquinary_pkg

// File: test/biquinary_code_translate_check_test.sv
/*
 * self-checking bench for the digit translators and validity checkers.
 * assumes the storage read source model beside it.
 */
`timescale 1ns/100ps
`default_nettype none
module biquinary_code_translate_check_test;
   logic clk = 1'b0;
   logic rst_n, fire, stg, btg, man, pbg, strobe, eres;
   logic [4:0] code;
   logic [6:0] dd, rb, acc, pgm, cdd;
   logic [4:0] sense, swr, rl;
   logic b_t, a_t, stop;
   logic [6:0] sel, pun;
   logic [2:0] err;
   int miscompares = 0;
   int checks = 0;
   // digits 0..9: bi-quinary code beside storage code
   logic [6:0] bq_row [10] = '{7'h05, 7'h09, 7'h11, 7'h21, 7'h41, 7'h06, 7'h0a, 7'h12, 7'h22, 7'h42};
   logic [4:0] sc_row [10] = '{5'h06, 5'h03, 5'h05, 5'h09, 5'h0a, 5'h0c, 5'h11, 5'h12, 5'h14, 5'h18};
   // extra binary, extra quinary, missing quinary
   logic [6:0] bad [3] = '{7'h07, 7'h0d, 7'h01};
   ////////////////////////////////////////////////////////////
   always #2 clk = ~clk;
   biquinary_code_translate_check dut (.clk(clk), .rst_n(rst_n), .dist_digit(dd), .read_buf_digit(rb),
      .store_transfer_gate(stg), .buffer_to_main_transfer_gate(btg), .storage_sense(sense), .b_time(b_t),
      .a_time(a_t), .manual_read_in(man), .punch_buffer_gate(pbg), .acc_digit(acc), .pgm_digit(pgm),
      .chk_dist_digit(cdd), .digit_strobe(strobe), .error_reset(eres), .storage_write(swr),
      .read_latch(rl), .selected_line(sel), .punch_buffer_out(pun), .error_light(err), .machine_stop(stop));
   storage_read_source src (.clk(clk), .rst_n(rst_n), .fire(fire), .code(code), .storage_sense(sense),
      .b_time(b_t), .a_time(a_t));
   ////////////////////////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task finish_test;
      $display("comparisons %0d mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   // one digit through both translators; every third digit takes the store
   // gate, digit 9 raises both gates, and the idle source carries another digit
   task run_digit(input int d);
      @(posedge clk);
      dd <= (d % 3 == 0) ? bq_row[d] : bq_row[9 - d];
      rb <= (d % 3 == 0) ? bq_row[9 - d] : bq_row[d];
      stg <= (d % 3 == 0);
      btg <= (d % 3 != 0) || (d == 9);
      code <= sc_row[d];
      fire <= 1'b1;
      acc <= bq_row[d];
      pgm <= bq_row[d];
      cdd <= bq_row[d];
      @(posedge clk);
      stg <= 1'b0;
      btg <= 1'b0;
      fire <= 1'b0;
      #1 chk(swr, sc_row[d]);
      tick(1);
      chk(swr, 7'h00);
      chk(rl, sc_row[d]);
      tick(1);
      chk(pun, pbg ? bq_row[d] : 7'h00);
      chk(sel, man ? 7'h00 : bq_row[d]);
      tick(2);
      chk(rl, 7'h00);
      chk(sel, 7'h00);
   endtask : run_digit
   ////////////////////////////////////////////////////////////
   // watchdog: the whole run needs well under 1000 cycles
   initial begin
      #10000;
      miscompares++;
      finish_test();
   end
   initial begin
      {rst_n, fire, stg, btg, man, eres} = 6'h00;
      {pbg, strobe} = 2'h3;
      code = 5'h00;
      {dd, rb, acc, pgm, cdd} = {5{7'h05}};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      chk({stop, err, sel}, 7'h00);
      chk({pun}, 7'h00);
      for (int i = 0; i < 10; i++) run_digit(i);
      chk({stop, err}, 7'h00);
      @(posedge clk);
      man <= 1'b1;
      pbg <= 1'b0;
      run_digit(7);
      @(posedge clk);
      man <= 1'b0;
      pbg <= 1'b1;
      strobe <= 1'b0;
      acc <= bad[0];
      tick(3);
      chk({stop, err}, 7'h00);
      @(posedge clk);
      acc <= 7'h05;
      strobe <= 1'b1;
      for (int u = 0; u < 3; u++) begin
         @(posedge clk);
         acc <= (u == 0) ? bad[u] : 7'h05;
         pgm <= (u == 1) ? bad[u] : 7'h05;
         cdd <= (u == 2) ? bad[u] : 7'h05;
         @(posedge clk);
         {acc, pgm, cdd} <= {3{7'h05}};
         tick(1);
         chk({stop, err}, 7'h08 | (7'h01 << u));
         tick(6);
         chk({stop, err}, 7'h08 | (7'h01 << u));
         @(posedge clk);
         eres <= 1'b1;
         @(posedge clk);
         eres <= 1'b0;
         tick(3);
         chk({stop, err}, 7'h00);
      end
      // a bad digit and the error reset in one cycle: the set wins
      @(posedge clk);
      acc <= bad[0];
      eres <= 1'b1;
      @(posedge clk);
      acc <= 7'h05;
      eres <= 1'b0;
      tick(2);
      chk({stop, err}, 16'h0009);
      // mid-run reset clears the latched error and every output
      @(posedge clk);
      rst_n <= 1'b0;
      tick(2);
      chk({stop, err}, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      tick(2);
      chk({stop, err, pun}, 16'h0000);
      finish_test();
   end
endmodule : biquinary_code_translate_check_test
`default_nettype wire

// File: test/storage_read_source.sv
/*
 * general storage read source: one recorded digit per fire request.
 * assumes fire and code change just after clk rises.
 */
`timescale 1ns/100ps
`default_nettype none
module storage_read_source (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronous reset
   input wire logic fire, // present one recorded digit
   input wire logic [4:0] code, // 2-of-5 digit to present
   output logic [4:0] storage_sense, // sensed head bits
   output logic b_time, // read sample pulse
   output logic a_time // latch reset pulse
);
   logic [1:0] cnt_q;
   ////////////////////////////////////////////////////////////
   // b pulse with the digit, a pulse two cycles on; sense bits
   // flip every cycle outside b so a stale digit looks valid only every other cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 2'h0;
         b_time <= 1'b0;
         a_time <= 1'b0;
         storage_sense <= 5'h00;
      end else begin
         b_time <= fire;
         a_time <= (cnt_q == 2'h1);
         storage_sense <= fire ? code : ~storage_sense;
         cnt_q <= fire ? 2'h2 : (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
      end
   end
endmodule : storage_read_source
`default_nettype wire
